/* File: link_partner.sv */
// Link training and data link model
`timescale 1ns/10ps
module link_partner (
    // Clock, reset and link requests
    input  wire logic       ref_clk, rst, retrain_pulse, link_disable, fail_mode,
    // Training and data link state
    output logic            train_active, train_fail, train_l0_ok, dl_active,
    output logic [5:0]      trained_width
);
    logic [3:0] cnt_q;
    assign train_active = cnt_q > 4'h1;
    assign train_l0_ok = cnt_q == 4'h1 && !fail_mode;
    assign train_fail = cnt_q == 4'h1 && fail_mode;
    assign trained_width = train_l0_ok ? 6'h04 : 6'h3b;
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            cnt_q <= 4'h0;
        else if (retrain_pulse)
            cnt_q <= 4'h9;
        else if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            dl_active <= 1'b0;
        else
            dl_active <= (dl_active || train_l0_ok) && !train_active && !link_disable;
endmodule

/* File: link_regs.sv */
// Link control and link status register pair of one switch port
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/10ps
`include "link_regs_map.svh"

// How it works
// - ASPM field: 00 none, 01 L0s allowed, 10 L1 allowed, 11 both.
// - Receiver may always enter L0s, even with ASPM fully disabled.
// - All link control fields reset to zero, so ASPM is off.
// - Read completion boundary bit always reads zero.
// - Downstream: link disable bit takes the link down; upstream hardwired zero.
// - Downstream: writing one to retrain starts retraining; upstream hardwired zero.
// - Retrain bit always reads back zero.
// - Common clock bit: 0 asynchronous clocks, 1 shared reference clock.
// - Extended sync: 4096 FTS leaving L0s, 1024 TS1 leaving L1.
// - Link speed field bits 19:16 reads 0001, meaning 2.5 Gb/s.
// - Width field bits 25:20 shows the trained lane width.
// - Training error sets on failed training, clears on training to L0.
// - Link training flag set during training, cleared when complete.
// - Slot clock bit from strap default, writable by loader path.
// - Data link active bit is one while in DL_Active, registered one clock after dl_active.
module link_regs #(
    parameter bit UPSTREAM   = 1'b0,
    parameter int MAX_WIDTH  = 6'd1
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Link training and data link state
    input  wire logic        train_active,
    input  wire logic        train_fail,
    input  wire logic        train_l0_ok,
    input  wire logic [5:0]  trained_width,
    input  wire logic        dl_active,
    // Slot clock default
    input  wire logic        slot_clk_strap,
    input  wire logic        slot_clk_load,
    input  wire logic        slot_clk_value,
    // Controls toward link logic
    output logic             l0s_tx_enable,
    output logic             l0s_rx_enable,
    output logic             l1_enable,
    output logic             link_disable,
    output logic             retrain_pulse,
    output logic             common_clock,
    output logic [12:0]      fts_count,
    output logic [10:0]      ts1_count
);

    // ****************************************
    // Parameter checks
    // ****************************************
    if (MAX_WIDTH < 1 || MAX_WIDTH > 32)
    begin : g_bad_width
        $error("link_regs: MAX_WIDTH out of range");
    end

    if (`WIDTH_RESET > MAX_WIDTH)
    begin : g_bad_reset_width
        $error("link_regs: reset width above MAX_WIDTH");
    end

    // ****************************************
    // Register state
    // ****************************************
    logic [1:0]  aspm_q;
    logic        link_dis_q;
    logic        common_clk_q;
    logic        ext_sync_q;
    logic        train_err_q;
    logic        training_q;
    logic [5:0]  width_q;
    logic        slot_clk_q;
    logic        strap_taken_q;
    logic        dl_active_q;
    link_regs_pkg::bus_state_t bus_q;

    function automatic logic hit(input logic [7:0] a);
        hit = (a == `LINK_CTRL_STAT_OFFSET);
    endfunction

    // Write lands at the edge where waitrequest is sampled low
    logic wr_ctrl;
    assign wr_ctrl = avs_write && bus_q == link_regs_pkg::bus_reply && hit(avs_address) && avs_byteenable[0];

    // ****************************************
    // Link control fields
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            aspm_q <= 2'h0;
        else if (wr_ctrl)
            aspm_q <= avs_writedata[`ASPM_HI:`ASPM_LO];
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            link_dis_q <= 1'b0;
        else if (wr_ctrl)
            link_dis_q <= UPSTREAM ? 1'b0 : avs_writedata[`LINK_DIS_BIT];
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            common_clk_q <= 1'b0;
        else if (wr_ctrl)
            common_clk_q <= avs_writedata[`COMMON_CLK_BIT];
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            ext_sync_q <= 1'b0;
        else if (wr_ctrl)
            ext_sync_q <= avs_writedata[`EXT_SYNC_BIT];
    end

    // Retrain is a one-cycle pulse, never stored
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            retrain_pulse <= 1'b0;
        else
            retrain_pulse <= wr_ctrl && !UPSTREAM && avs_writedata[`RETRAIN_BIT];
    end

    // ****************************************
    // Control outputs
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            l0s_tx_enable <= 1'b0;
        else
            l0s_tx_enable <= aspm_q[0];
    end

    // Receiver side keeps L0s whatever the ASPM field holds
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            l0s_rx_enable <= 1'b1;
        else
            l0s_rx_enable <= 1'b1;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            l1_enable <= 1'b0;
        else
            l1_enable <= aspm_q[1];
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            link_disable <= 1'b0;
        else
            link_disable <= link_dis_q;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            common_clock <= 1'b0;
        else
            common_clock <= common_clk_q;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            fts_count <= 13'(`FTS_STD_COUNT);
        else if (ext_sync_q)
            fts_count <= 13'(`FTS_EXT_COUNT);
        else
            fts_count <= 13'(`FTS_STD_COUNT);
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            ts1_count <= 11'(`TS1_STD_COUNT);
        else if (ext_sync_q)
            ts1_count <= 11'(`TS1_EXT_COUNT);
        else
            ts1_count <= 11'(`TS1_STD_COUNT);
    end

    // ****************************************
    // Link status fields
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            train_err_q <= 1'b0;
        else if (train_fail)
            train_err_q <= 1'b1;
        else if (train_l0_ok)
            train_err_q <= 1'b0;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            training_q <= 1'b0;
        else
            training_q <= train_active;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            width_q <= `WIDTH_RESET;
        else if (train_l0_ok)
            width_q <= trained_width;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            dl_active_q <= 1'b0;
        else
            dl_active_q <= dl_active;
    end

    // Strap caught on the first edge after reset, loader may override later
    // Strap capture wins over a loader write in the same cycle
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            slot_clk_q    <= 1'b0;
            strap_taken_q <= 1'b0;
        end
        else if (!strap_taken_q)
        begin
            slot_clk_q    <= slot_clk_strap;
            strap_taken_q <= 1'b1;
        end
        else if (slot_clk_load)
            slot_clk_q <= slot_clk_value;
    end

    // ****************************************
    // Read word assembly
    // ****************************************
    logic [31:0] rd_word;
    always_comb
    begin
        rd_word                             = 32'h0000_0000;
        rd_word[`ASPM_HI:`ASPM_LO]          = aspm_q;
        rd_word[`RCB_BIT]                   = 1'b0;
        rd_word[`LINK_DIS_BIT]              = link_dis_q;
        rd_word[`RETRAIN_BIT]               = 1'b0;
        rd_word[`COMMON_CLK_BIT]            = common_clk_q;
        rd_word[`EXT_SYNC_BIT]              = ext_sync_q;
        rd_word[`SPEED_HI:`SPEED_LO]        = `SPEED_2G5;
        rd_word[`WIDTH_HI:`WIDTH_LO]        = width_q;
        rd_word[`TRAIN_ERR_BIT]             = train_err_q;
        rd_word[`TRAINING_BIT]              = training_q;
        rd_word[`SLOT_CLK_BIT]              = slot_clk_q;
        rd_word[`DL_ACTIVE_BIT]             = dl_active_q;
    end

    // ****************************************
    // Avalon-MM handshake
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            bus_q <= link_regs_pkg::bus_idle;
        else
        begin
            case (bus_q)
                link_regs_pkg::bus_idle:
                begin
                    if (avs_read || avs_write)
                        bus_q <= link_regs_pkg::bus_reply;
                end
                link_regs_pkg::bus_reply:
                    bus_q <= link_regs_pkg::bus_idle;
                default:
                    bus_q <= link_regs_pkg::bus_idle;
            endcase
        end
    end

    // One wait cycle for every access
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            avs_waitrequest <= 1'b1;
        else if (bus_q == link_regs_pkg::bus_idle && (avs_read || avs_write))
            avs_waitrequest <= 1'b0;
        else
            avs_waitrequest <= 1'b1;
    end

    // Read data captured one edge before waitrequest is sampled low, stands until the next read
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            avs_readdata <= 32'h0000_0000;
        else if (bus_q == link_regs_pkg::bus_idle && avs_read)
        begin
            if (hit(avs_address))
                avs_readdata <= rd_word;
            else
                avs_readdata <= `UNMAPPED_READ;
        end
    end

endmodule

/* File: link_regs_assertions.sv */
// Port checks of the link register block
`timescale 1ns/10ps
module link_regs_checker #(parameter bit UPSTREAM = 1'b0, parameter int MAX_WIDTH = 6'd1) (
    // Bus and link control ports
    input wire logic        ref_clk, rst, avs_read, avs_write, avs_waitrequest, retrain_pulse,
    input wire logic        l0s_tx_enable, l0s_rx_enable, l1_enable, link_disable, common_clock,
    input wire logic [7:0]  avs_address,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_writedata, avs_readdata,
    input wire logic [12:0] fts_count,
    input wire logic [10:0] ts1_count
);
    logic       wr_ok, rd_ok, hit;
    logic [7:0] ctrl_q;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    assign hit = avs_address == 8'hf0;
    assign wr_ok = avs_write && !avs_waitrequest && hit && avs_byteenable[0];
    assign rd_ok = avs_read && !avs_waitrequest;
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            ctrl_q <= 8'h00;
        else if (wr_ok)
            ctrl_q <= avs_writedata[7:0];
    a_ctrl_copy: assert property (wr_ok |-> ##[1:2] {l1_enable, l0s_tx_enable} == ctrl_q[1:0]
        && link_disable == (ctrl_q[4] && !UPSTREAM) && common_clock == ctrl_q[6]) else $error("bad controls");
    a_sync_count: assert property (wr_ok |-> ##[1:2] fts_count == (ctrl_q[7] ? 13'd4096 : 13'd255)
        && ts1_count == (ctrl_q[7] ? 11'd1024 : 11'd16)) else $error("bad sync counts");
    a_rx_l0s_on: assert property (l0s_rx_enable) else $error("rx L0s off");
    a_retrain_go: assert property (wr_ok && avs_writedata[5] && !UPSTREAM |-> ##[1:2] retrain_pulse)
        else $error("no retrain");
    a_ctrl_read: assert property (rd_ok && hit |-> avs_readdata[15:0] == {8'h00, ctrl_q & 8'hd3})
        else $error("bad readback");
    a_speed_fixed: assert property (rd_ok && hit |-> avs_readdata[19:16] == 4'h1)
        else $error("bad speed");
    a_unmapped_zero: assert property (rd_ok && !hit |-> avs_readdata == 32'h0) else $error("bad unmapped");
    a_reset_ctrl: assert property ($fell(rst) |-> !l1_enable && !link_disable && fts_count == 13'd255)
        else $error("bad reset");
    c_write: cover property (wr_ok);
    c_read: cover property (rd_ok);
    c_retrain: cover property (retrain_pulse);
endmodule
bind link_regs link_regs_checker #(.UPSTREAM(UPSTREAM), .MAX_WIDTH(MAX_WIDTH)) chk_i (.*);

/* File: link_regs_map.svh */
// Offsets, field positions, reset values and timing counts of the link control/status word
`ifndef LINK_REGS_MAP_SVH
`define LINK_REGS_MAP_SVH

`define LINK_CTRL_STAT_OFFSET   8'hf0
`define ASPM_LO                 0
`define ASPM_HI                 1
`define RCB_BIT                 3
`define LINK_DIS_BIT            4
`define RETRAIN_BIT             5
`define COMMON_CLK_BIT          6
`define EXT_SYNC_BIT            7
`define SPEED_LO                16
`define SPEED_HI                19
`define WIDTH_LO                20
`define WIDTH_HI                25
`define TRAIN_ERR_BIT           26
`define TRAINING_BIT            27
`define SLOT_CLK_BIT            28
`define DL_ACTIVE_BIT           29
`define CTRL_RESET              8'h00
`define SPEED_2G5               4'h1
`define WIDTH_RESET             6'h01
`define FTS_EXT_COUNT           4096
`define FTS_STD_COUNT           255
`define TS1_EXT_COUNT           1024
`define TS1_STD_COUNT           16
`define UNMAPPED_READ           32'h0000_0000

`endif

/* File: link_regs_pkg.sv */
// Types shared by the link control and status register block
package link_regs_pkg;

    typedef enum logic [1:0] {
        aspm_off      = 2'h0,
        aspm_l0s      = 2'h1,
        aspm_l1       = 2'h2,
        aspm_l0s_l1   = 2'h3
    } aspm_mode_t;

    typedef enum logic [1:0] {
        bus_idle  = 2'h1,
        bus_reply = 2'h2
    } bus_state_t;

endpackage

/* File: link_regs_tb_top.sv */
// Self-checking bench of the link register block
`timescale 1ns/10ps
module link_regs_tb_top;
    logic        ref_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, fail_mode = 1'b0;
    logic        slot_clk_load = 1'b0, slot_clk_value = 1'b1;
    logic        avs_waitrequest, train_active, train_fail, train_l0_ok, dl_active;
    logic        l0s_tx_enable, l0s_rx_enable, l1_enable, link_disable, retrain_pulse, common_clock;
    logic [7:0]  avs_address = 8'h00;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [5:0]  trained_width;
    logic [12:0] fts_count;
    logic [10:0] ts1_count;
    int          err_total = 0, samples_checked = 0;
    always #2 ref_clk = ~ref_clk;
    link_regs uut (.*, .slot_clk_strap(1'b1));
    link_partner peer (.*);
    task automatic cmp(input logic [31:0] got, exp);
        samples_checked++;
        err_total += int'(got !== exp);
        if (got !== exp)
            $display("Error %0t: got %h want %h", $time, got, exp);
    endtask
    task automatic acc(input logic wr, logic [7:0] a, logic [31:0] d, logic [3:0] be);
        int n;
        n = 0;
        {avs_write, avs_read, avs_address, avs_writedata, avs_byteenable} <= {wr, !wr, a, d, be};
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0 && n < 40)
        begin
            @(posedge ref_clk);
            n++;
        end
        err_total += int'(n == 40);
        rd = avs_readdata;
        {avs_write, avs_read} <= 2'h0;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic rdc(input logic [31:0] m, exp);
        acc(1'b0, 8'hf0, 32'h0, 4'hf);
        cmp(rd & m, exp);
    endtask
    task automatic t_ctrl;
        rdc(32'hffff_ffff, 32'h1011_0000);
        for (int m = 0; m < 4; m++)
        begin
            acc(1'b1, 8'hf0, 32'(m), 4'hf);
            cmp({l1_enable, l0s_tx_enable, l0s_rx_enable}, 32'(m * 2 + 1));
        end
        acc(1'b1, 8'hf0, 32'hffff_ffff, 4'hf);
        cmp({link_disable, common_clock, fts_count, ts1_count}, {2'h3, 13'd4096, 11'd1024});
        rdc(32'hc000_ffff, 32'h0000_00d3);
        acc(1'b1, 8'hf0, 32'h0, 4'he);
        acc(1'b1, 8'he0, 32'h0, 4'hf);
        acc(1'b0, 8'he0, 32'h0, 4'hf);
        cmp(rd, 32'h0);
        rdc(32'h0000_ffff, 32'h0000_00d3);
        acc(1'b1, 8'hf0, 32'h0, 4'hf);
        cmp({link_disable, common_clock, fts_count, ts1_count}, {2'h0, 13'd255, 11'd16});
    endtask
    task automatic t_train;
        acc(1'b1, 8'hf0, 32'h20, 4'hf);
        repeat (2) @(posedge ref_clk);
        rdc(32'h0800_0000, 32'h0800_0000);
        repeat (12) @(posedge ref_clk);
        rdc(32'h3ff0_0000, 32'h3040_0000);
        fail_mode <= 1'b1;
        acc(1'b1, 8'hf0, 32'h20, 4'hf);
        repeat (14) @(posedge ref_clk);
        rdc(32'h2c00_0000, 32'h0400_0000);
        fail_mode <= 1'b0;
        acc(1'b1, 8'hf0, 32'h20, 4'hf);
        repeat (14) @(posedge ref_clk);
        rdc(32'h2c00_0000, 32'h2000_0000);
        slot_clk_value <= 1'b0;
        slot_clk_load  <= 1'b1;
        @(posedge ref_clk);
        slot_clk_load  <= 1'b0;
        rdc(32'h1000_0000, 32'h0000_0000);
    endtask
    task automatic test_done;
        if (err_total == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_ctrl;
        t_train;
        test_done;
    end
    initial
    begin
        repeat (3000) @(posedge ref_clk);
        err_total++;
        test_done;
    end
endmodule
